/* File: vds_seq.sv */
// Operation
// RULE1: Start soft-start only when supply is above rise threshold and enabled.
// RULE2: Supply below fall threshold disables all converter operation.
// RULE3: Enable high or open counts as permission to start.
// RULE4: First phase uses low ramp current until ramp reaches 0.9V.
// RULE5: At 0.9V switch to high current, track reference, flag done.
// RULE6: Above 0.9V ramp sources and sinks to follow the code.
// RULE7: I/O soft-start follows the core ramp and ends with it.
// RULE8: Code changes during run move reference at ramp slew. The code steps core_ref_mv to the new level at once, with no slew.
// RULE9: Low-half codes decode 2.00V down to 1.30V in 50mV steps.
// RULE10: High-half codes decode 1.275V down to 0.925V in 25mV steps.
// RULE11: Codes 01111 and 11111 shut down and force output good low.
// RULE12: Open code pins read as one through pull-ups.
// RULE13: Good, under and over thresholds derive from decoded reference.
// RULE14: Processor grounds a bit for zero, opens it for one.
// RULE15: Light load with discontinuous current selects hysteretic mode.
// RULE16: Hysteretic comparator decisions are synchronised to main clock.
// RULE17: Continuous inductor current returns converter to PWM.
// RULE18: Latched fault clears when enable cycles low then high.
// RULE19: Output good low when core output outside ten percent window.
// RULE20: All comparator flags pass two flip-flops before use.
`timescale 1ns/1ps
module vds_seq (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pins, already resolved with pull-ups high when open
    input wire logic enable_pin,
    input wire logic [4:0] voltage_code_bits,
    // Comparator flags
    input wire logic supply_above_rise,
    input wire logic supply_below_fall,
    input wire logic ramp_at_thresh,
    input wire logic ramp_at_ref,
    input wire logic core_in_window,
    input wire logic io_in_window,
    input wire logic undervoltage_protection,
    input wire logic overvoltage_protection,
    input wire logic [1:0] inductor_continuous,
    input wire logic [1:0] hyst_compare,
    // Control outputs
    output logic converters_on,
    output logic ramp_low_current,
    output logic ramp_high_current,
    output logic ramp_track,
    output logic io_ramp_on,
    output logic softstart_done,
    output logic fault_latched,
    output logic output_good_flag,
    output logic [1:0] hyst_mode,
    output logic [1:0] hyst_decision,
    output logic [11:0] core_ref_mv,
    output logic [11:0] good_lo_mv,
    output logic [11:0] good_hi_mv
);

    // ***********************
    // Input synchronisers
    // ***********************
    localparam int NS = 18;
    wire [NS-1:0] raw = {enable_pin, voltage_code_bits, supply_above_rise,
        supply_below_fall, ramp_at_thresh, ramp_at_ref, core_in_window,
        io_in_window, undervoltage_protection, overvoltage_protection,
        inductor_continuous, hyst_compare};
    logic [NS-1:0] sync1;
    logic [NS-1:0] sync2;
    localparam logic [NS-1:0] SYNC_RESET = {1'b0, 5'h1f, 12'h000};

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= SYNC_RESET;
            sync2 <= SYNC_RESET;
        end else begin
            sync1 <= raw; // [RULE20]
            sync2 <= sync1; // [RULE20]
        end
    end

    wire en_s = sync2[17];
    wire [4:0] code_s = sync2[16:12]; // [RULE12] [RULE14]
    wire rise_s = sync2[11];
    wire fall_s = sync2[10];
    wire thresh_s = sync2[9];
    wire core_ok_s = sync2[7];
    wire io_ok_s = sync2[6];
    wire uv_s = sync2[5];
    wire ov_s = sync2[4];
    wire [1:0] cont_s = sync2[3:2];
    wire [1:0] hcmp_s = sync2[1:0];

    // ***********************
    // Code qualification
    // ***********************
    // Pin skew can pass a false no-processor code
    logic [4:0] code_prev;
    logic [4:0] code_ok;
    wire code_steady = (code_s == code_prev);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            code_prev <= vds_pkg::CODE_RESET;
            code_ok <= vds_pkg::CODE_RESET;
        end else begin
            code_prev <= code_s;
            if (code_steady) begin
                code_ok <= code_s; // [RULE8]
            end
        end
    end

    // ***********************
    // Reference decode
    // ***********************
    vds_ref_if rif ();
    assign rif.code = code_ok; // [RULE8]
    vds_ref_decode u_dec (
        .rif(rif)
    );

    // ***********************
    // Sequencer
    // ***********************
    vds_pkg::vds_state_t state;
    vds_pkg::vds_state_t next_state;
    logic en_prev;
    logic powered;
    wire en_rise = en_s && !en_prev;
    wire kill = fall_s || !en_s || rif.no_cpu; // [RULE2] [RULE11]
    wire start_ok = powered && en_s && !rif.no_cpu; // [RULE1] [RULE3]

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            powered <= 1'b0;
        end else if (fall_s) begin
            powered <= 1'b0; // [RULE2]
        end else if (rise_s) begin
            powered <= 1'b1; // [RULE1]
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            vds_pkg::VDS_OFF: begin
                if (start_ok) begin
                    next_state = vds_pkg::VDS_SLOW; // [RULE1]
                end
            end
            vds_pkg::VDS_SLOW: begin
                if (kill || !powered) begin
                    next_state = vds_pkg::VDS_OFF;
                end else if (uv_s) begin
                    next_state = vds_pkg::VDS_FAULT;
                end else if (thresh_s) begin
                    next_state = vds_pkg::VDS_RUN; // [RULE5]
                end
            end
            vds_pkg::VDS_RUN: begin
                if (kill || !powered) begin
                    next_state = vds_pkg::VDS_OFF;
                end else if (uv_s) begin
                    next_state = vds_pkg::VDS_FAULT;
                end
            end
            vds_pkg::VDS_FAULT: begin
                if (fall_s) begin
                    next_state = vds_pkg::VDS_OFF; // [RULE2]
                end else if (!en_s) begin
                    next_state = vds_pkg::VDS_OFF; // [RULE18]
                end
            end
            default: begin
                next_state = vds_pkg::VDS_OFF;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= vds_pkg::VDS_OFF;
            en_prev <= 1'b0;
        end else begin
            state <= next_state;
            en_prev <= en_s;
        end
    end

    // ***********************
    // Outputs
    // ***********************
    wire in_slow = (next_state == vds_pkg::VDS_SLOW);
    wire in_run = (next_state == vds_pkg::VDS_RUN);
    wire good_now = in_run && core_ok_s && io_ok_s && !uv_s && !ov_s;

    // Mode selection per converter
    logic [1:0] next_hyst;
    always_comb begin
        next_hyst = hyst_mode;
        for (int i = 0; i < 2; i++) begin
            if (!(in_slow || in_run)) begin
                next_hyst[i] = 1'b0;
            end else if (!cont_s[i]) begin
                next_hyst[i] = 1'b1; // [RULE15]
            end else begin
                next_hyst[i] = 1'b0; // [RULE17]
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            converters_on <= 1'b0;
            ramp_low_current <= 1'b0;
            ramp_high_current <= 1'b0;
            ramp_track <= 1'b0;
            io_ramp_on <= 1'b0;
            softstart_done <= 1'b0;
            fault_latched <= 1'b0;
            output_good_flag <= 1'b0;
            hyst_mode <= 2'h0;
            hyst_decision <= 2'h0;
            core_ref_mv <= vds_pkg::REF_RESET_MV;
            good_lo_mv <= vds_pkg::REF_RESET_MV;
            good_hi_mv <= vds_pkg::REF_RESET_MV;
        end else begin
            converters_on <= in_slow || in_run; // [RULE2]
            ramp_low_current <= in_slow; // [RULE4]
            ramp_high_current <= in_run; // [RULE5]
            ramp_track <= in_run; // [RULE6]
            io_ramp_on <= in_slow || in_run; // [RULE7]
            softstart_done <= in_run; // [RULE5] [RULE7]
            fault_latched <= (next_state == vds_pkg::VDS_FAULT);
            output_good_flag <= good_now && !rif.no_cpu; // [RULE11] [RULE19]
            hyst_mode <= next_hyst;
            hyst_decision <= next_hyst & hcmp_s; // [RULE16]
            core_ref_mv <= rif.ref_mv; // [RULE8] [RULE13]
            good_lo_mv <= rif.good_lo_mv; // [RULE13]
            good_hi_mv <= rif.good_hi_mv; // [RULE13]
        end
    end

    // ***********************
    // Assertions
    // ***********************
    AST_NOCPU_NOT_GOOD: assert property ( // [RULE11]
        @(posedge clock) disable iff (!reset_n)
        rif.no_cpu |=> !output_good_flag)
        else $error("output good high with no processor code");

    AST_FALL_OFF: assert property ( // [RULE2]
        @(posedge clock) disable iff (!reset_n)
        fall_s |=> !converters_on)
        else $error("converters on after supply fall");

    AST_START_NEEDS_POWER: assert property ( // [RULE1]
        @(posedge clock) disable iff (!reset_n)
        $rose(ramp_low_current) |-> $past(powered) && $past(en_s))
        else $error("soft-start began without supply and enable");

    AST_SLOW_EXCL: assert property ( // [RULE4]
        @(posedge clock) disable iff (!reset_n)
        !(ramp_low_current && ramp_high_current))
        else $error("both ramp currents selected");

    AST_DONE_AFTER_THRESH: assert property ( // [RULE5]
        @(posedge clock) disable iff (!reset_n)
        $rose(softstart_done) |-> $past(thresh_s))
        else $error("soft-start done without ramp threshold");

    AST_IO_FOLLOWS: assert property ( // [RULE7]
        @(posedge clock) disable iff (!reset_n)
        softstart_done |-> io_ramp_on && ramp_track)
        else $error("io ramp not slaved to core ramp");

    AST_GOOD_WINDOW: assert property ( // [RULE19]
        @(posedge clock) disable iff (!reset_n)
        !core_ok_s |=> !output_good_flag)
        else $error("output good high outside window");

    AST_HYST_DISC: assert property ( // [RULE15]
        @(posedge clock) disable iff (!reset_n)
        converters_on && next_state != vds_pkg::VDS_OFF && !cont_s[0]
        && next_state != vds_pkg::VDS_FAULT |=> hyst_mode[0])
        else $error("hysteretic mode not entered");

    AST_PWM_BACK: assert property ( // [RULE17]
        @(posedge clock) disable iff (!reset_n)
        cont_s[1] |=> !hyst_mode[1])
        else $error("pwm not restored");

    AST_FAULT_HOLD: assert property ( // [RULE18]
        @(posedge clock) disable iff (!reset_n)
        fault_latched && en_s && !fall_s |=> fault_latched)
        else $error("fault cleared without enable cycle");

    AST_RESTART_ON_EN: assert property ( // [RULE18]
        @(posedge clock) disable iff (!reset_n)
        state == vds_pkg::VDS_OFF && en_rise && start_ok |=> ramp_low_current)
        else $error("enable rise did not restart soft-start");

    AST_RUN_HIGH_CURRENT: assert property ( // [RULE5]
        @(posedge clock) disable iff (!reset_n)
        softstart_done |-> ramp_high_current && !ramp_low_current)
        else $error("high ramp current missing after soft-start");

    AST_LOW_IN_SLOW: assert property ( // [RULE4]
        @(posedge clock) disable iff (!reset_n)
        ramp_low_current |-> converters_on && !softstart_done)
        else $error("low ramp current outside first phase");

    AST_REF_THRESH: assert property ( // [RULE13]
        @(posedge clock) disable iff (!reset_n)
        core_ref_mv != vds_pkg::REF_RESET_MV
        |-> good_lo_mv < core_ref_mv && good_hi_mv > core_ref_mv)
        else $error("thresholds not around the reference");

    AST_HYST_SYNC: assert property ( // [RULE16]
        @(posedge clock) disable iff (!reset_n)
        hyst_decision == (hyst_mode & $past(hcmp_s)))
        else $error("hysteretic decision not clocked from comparator");

    AST_POWER_GATE: assert property ( // [RULE2]
        @(posedge clock) disable iff (!reset_n)
        !powered |=> !converters_on)
        else $error("converters on without supply");

endmodule : vds_seq

/* File: vds_pkg.sv */
package vds_pkg;

    // Reference level in millivolts
    localparam int REF_W = 12;
    localparam logic [11:0] REF_HI_BASE_MV = 12'h7d0;
    localparam logic [11:0] REF_HI_STEP_MV = 12'h032;
    localparam logic [11:0] REF_LO_BASE_MV = 12'h4fb;
    localparam logic [11:0] REF_LO_STEP_MV = 12'h019;
    localparam logic [11:0] REF_RESET_MV = 12'h000;
    localparam logic [4:0] CODE_RESET = 5'h1f;
    localparam logic [4:0] CODE_OFF_LO = 5'h0f;
    localparam logic [4:0] CODE_OFF_HI = 5'h1f;

    // Tolerance window for output good, in percent
    localparam int GOOD_TOL_PCT = 10;

    // Sequencer states, Gray along the start-up path
    typedef enum logic [1:0] {
        VDS_OFF = 2'b00,
        VDS_SLOW = 2'b01,
        VDS_RUN = 2'b11,
        VDS_FAULT = 2'b10
    } vds_state_t;

endpackage : vds_pkg

/* File: vds_ref_if.sv */
`timescale 1ns/1ps
interface vds_ref_if;
    logic [4:0] code;
    logic [11:0] ref_mv;
    logic [11:0] good_lo_mv;
    logic [11:0] good_hi_mv;
    logic no_cpu;

    modport dec (input code, output ref_mv, good_lo_mv, good_hi_mv, no_cpu);
    modport seq (output code, input ref_mv, good_lo_mv, good_hi_mv, no_cpu);
endinterface : vds_ref_if

/* File: vds_ref_decode.sv */
`timescale 1ns/1ps
module vds_ref_decode (
    vds_ref_if.dec rif
);

    // ***********************
    // Code to reference level
    // ***********************
    function automatic logic [11:0] vds_level(input logic [4:0] c);
        logic [11:0] idx;
        idx = {8'h00, c[3:0]};
        if (c[4]) begin
            vds_level = 12'(vds_pkg::REF_LO_BASE_MV -
                12'(idx * vds_pkg::REF_LO_STEP_MV));
        end else begin
            vds_level = 12'(vds_pkg::REF_HI_BASE_MV -
                12'(idx * vds_pkg::REF_HI_STEP_MV));
        end
    endfunction : vds_level

    wire [11:0] level_mv = vds_level(rif.code); // [RULE9] [RULE10]
    wire [11:0] base_mv = rif.no_cpu ? vds_pkg::REF_RESET_MV : level_mv;
    wire [15:0] tol_mv = 16'({4'h0, base_mv} * 16'(vds_pkg::GOOD_TOL_PCT))
        / 16'h0064;

    assign rif.no_cpu = (rif.code == vds_pkg::CODE_OFF_LO) ||
        (rif.code == vds_pkg::CODE_OFF_HI); // [RULE11]
    assign rif.ref_mv = base_mv;
    // Thresholds share the same reference
    assign rif.good_lo_mv = 12'(base_mv - tol_mv[11:0]); // [RULE13] [RULE19]
    assign rif.good_hi_mv = 12'(base_mv + tol_mv[11:0]); // [RULE13]

endmodule : vds_ref_decode

/* File: vds_cpu_model.sv */
`timescale 1ns/1ps
module vds_cpu_model (
    // Code wanted by the processor
    input wire logic [4:0] code_want,
    // Bits left floating
    input wire logic [4:0] pin_open,
    // Pins at the device
    output logic [4:0] voltage_code_bits
);
    // Grounded bit reads 0, floating bit pulled to 1
    assign voltage_code_bits = code_want | pin_open;
endmodule : vds_cpu_model

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic en = 1'b0;
    logic up = 1'b0;
    logic down = 1'b0;
    logic thr = 1'b0;
    logic cw = 1'b0;
    logic iw = 1'b0;
    logic uv = 1'b0;
    logic ov = 1'b0;
    logic [1:0] cont = 2'h3;
    logic [1:0] hc = 2'h0;
    logic [4:0] code_want = 5'h00;
    logic [4:0] pin_open = 5'h00;
    logic [4:0] vcode;
    logic on, rl, rh, rt, io, done, flt, good;
    logic [1:0] hm, hd;
    logic [11:0] refm, glo, ghi, st;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    // Status word: on, low, high, track, io, done, fault, good
    assign st = {4'h0, on, rl, rh, rt, io, done, flt, good};
    always #5 clock = ~clock;
    vds_cpu_model cpu (.code_want(code_want), .pin_open(pin_open),
        .voltage_code_bits(vcode));
    vds_seq dut (.clock(clock), .reset_n(reset_n), .enable_pin(en),
        .voltage_code_bits(vcode), .supply_above_rise(up),
        .supply_below_fall(down), .ramp_at_thresh(thr), .ramp_at_ref(1'b0),
        .core_in_window(cw), .io_in_window(iw),
        .undervoltage_protection(uv), .overvoltage_protection(ov),
        .inductor_continuous(cont), .hyst_compare(hc),
        .converters_on(on), .ramp_low_current(rl), .ramp_high_current(rh),
        .ramp_track(rt), .io_ramp_on(io), .softstart_done(done),
        .fault_latched(flt), .output_good_flag(good), .hyst_mode(hm),
        .hyst_decision(hd), .core_ref_mv(refm), .good_lo_mv(glo),
        .good_hi_mv(ghi));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    function automatic logic [11:0] exp_ref(input logic [4:0] c);
        if (c == 5'h0f || c == 5'h1f) return 12'h000;
        if (!c[4]) return vds_pkg::REF_HI_BASE_MV - vds_pkg::REF_HI_STEP_MV * c;
        return vds_pkg::REF_LO_BASE_MV - vds_pkg::REF_LO_STEP_MV * c[3:0];
    endfunction : exp_ref
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_start();
        @(posedge clock);
        up <= 1'b1;
        step(5);
        check(st, 12'h000);
        @(posedge clock);
        en <= 1'b1;
        step(5);
        check(st, 12'h0c8);
        @(posedge clock);
        cw <= 1'b1;
        iw <= 1'b1;
        thr <= 1'b1;
        step(6);
        check(st, 12'h0bd);
        $display("t_start done");
    endtask : t_start
    task automatic t_decode();
        logic [11:0] e;
        for (int i = 0; i < 33; i++) begin
            @(posedge clock);
            code_want <= (i == 32) ? 5'h00 : 5'(i);
            pin_open <= (i == 32) ? 5'h0f : 5'h00;
            step(10);
            e = exp_ref((i == 32) ? 5'h0f : 5'(i));
            check(refm, e);
            check(12'({on, good}), (e == 0) ? 12'h0 : 12'h3);
            if (e != 0) check(12'(glo < refm && ghi > refm), 12'h1);
            check(glo, 12'(e - e / 12'h00a));
            check(ghi, 12'(e + e / 12'h00a));
        end
        @(posedge clock);
        pin_open <= 5'h00;
        code_want <= 5'h06;
        step(10);
        $display("t_decode done");
    endtask : t_decode
    task automatic t_good();
        @(posedge clock);
        cw <= 1'b0;
        step(5);
        check(st, 12'h0bc);
        @(posedge clock);
        cw <= 1'b1;
        ov <= 1'b1;
        step(5);
        check(st, 12'h0bc);
        @(posedge clock);
        ov <= 1'b0;
        step(5);
        check(st, 12'h0bd);
        $display("t_good done");
    endtask : t_good
    task automatic t_fault();
        @(posedge clock);
        uv <= 1'b1;
        step(5);
        check(st, 12'h002);
        @(posedge clock);
        uv <= 1'b0;
        step(5);
        check(st, 12'h002);
        @(posedge clock);
        en <= 1'b0;
        thr <= 1'b0;
        step(5);
        check(st, 12'h000);
        @(posedge clock);
        en <= 1'b1;
        step(5);
        check(st, 12'h0c8);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_hyst();
        @(posedge clock);
        cont <= 2'b01;
        hc <= 2'b11;
        step(5);
        check(12'({hm, hd}), 12'h00a);
        @(posedge clock);
        cont <= 2'b10;
        step(5);
        check(12'({hm, hd}), 12'h005);
        @(posedge clock);
        cont <= 2'b11;
        step(5);
        check(12'({hm, hd}), 12'h000);
        $display("t_hyst done");
    endtask : t_hyst
    task automatic t_supply();
        @(posedge clock);
        down <= 1'b1;
        step(5);
        check(st, 12'h000);
        $display("t_supply done");
    endtask : t_supply
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        step(10);
        check(st, 12'h000);
        check(refm, 12'h000);
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        t_start();
        t_decode();
        t_good();
        t_fault();
        t_hyst();
        t_supply();
        test_done();
    end
endmodule : tb_top
